/* File: verilog/lcr_pkg.sv */
// constants for the regulator control register bank
// assumes an 8-bit register port with 8-bit addresses
package lcr_pkg;
   localparam int CHAN_COUNT = 4;
   localparam logic [7:0] ADDR_A_LEVEL = 8'h50;
   localparam logic [7:0] ADDR_A_CONTROL = 8'h51;
   localparam logic [7:0] ADDR_B_LEVEL = 8'h54;
   localparam logic [7:0] ADDR_B_CONTROL = 8'h55;
   localparam logic [7:0] ADDR_C_LEVEL = 8'h60;
   localparam logic [7:0] ADDR_C_CONTROL = 8'h61;
   localparam logic [7:0] ADDR_D_LEVEL = 8'h64;
   localparam logic [7:0] ADDR_D_CONTROL = 8'h65;
   localparam int LEVEL_MSB = 5;
   localparam int BIT_ENABLE = 7;
   localparam int BIT_BLEED = 6;
   localparam int BIT_QUIET = 5;
   localparam int WAIT_MSB = 4;
   localparam int WAIT_LSB = 2;
   localparam int BIT_FAULT_ALLOW = 1;
   localparam int BIT_GOOD = 0;
   localparam logic [5:0] LEVEL_RESET = 6'h00;
   localparam logic [6:0] CONTROL_RESET = 7'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage

/* File: verilog/lcr_chan_mem.sv */
// per-channel storage of level and writable control bits
// assumes writes come from the register bank on clk_sys
`timescale 1ns/1ps
`default_nettype none
module lcr_chan_mem
   import lcr_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // write side
   input wire logic writeLevel,
   input wire logic writeControl,
   input wire logic [1:0] chanSel,
   input wire logic [7:0] writeData,
   // stored values
   output logic [CHAN_COUNT*6-1:0] levelAll,
   output logic [CHAN_COUNT*7-1:0] controlAll
);
   typedef struct packed {
      logic [CHAN_COUNT-1:0][5:0] level;
      logic [CHAN_COUNT-1:0][6:0] control;
   } lcr_mem_type;

   lcr_mem_type state;
   lcr_mem_type next_state;

   // only writable bits are captured
   always_comb begin
      next_state = state;
      if (writeLevel) begin
         next_state.level[chanSel] = writeData[LEVEL_MSB:0]; // RL1
      end
      if (writeControl) begin
         next_state.control[chanSel] = writeData[7:1]; // RL8
      end
   end

   // storage registers
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state <= '{level: {CHAN_COUNT{LEVEL_RESET}}, control: {CHAN_COUNT{CONTROL_RESET}}};
      end else begin
         state <= next_state;
      end
   end

   assign levelAll = state.level;
   assign controlAll = state.control;
endmodule
`default_nettype wire

/* File: verilog/lcr_bank.sv */
// register bank for four linear regulator channels
// assumes a serial interface front end delivers byte reads/writes on clk_sys
// What this block does
// (RL1) each channel level register holds six-bit level code; bits 7:6 read zero
// (RL2) control bit 7 enables the regulator; one on, zero off
// (RL3) control bit 6 selects output bleed while the channel is shut down
// (RL4) control bit 5 selects low quiescent operation
// (RL5) control bits 4:2 hold the turn-on wait code
// (RL6) control bit 1 lets a channel fault raise the interrupt
// (RL7) control bit 0 reads live power-good, read only
// (RL8) writes to reserved or read-only bits change nothing
`timescale 1ns/1ps
`default_nettype none
module lcr_bank
   import lcr_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // register port from serial interface
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWriteData,
   output logic [7:0] regReadData,
   output logic regHit,
   // analog status from the channels
   input wire logic [CHAN_COUNT-1:0] powerGoodPin,
   input wire logic [CHAN_COUNT-1:0] faultPin,
   // controls to the channels
   output logic [CHAN_COUNT*6-1:0] outputLevelCode,
   output logic [CHAN_COUNT-1:0] chanEnable,
   output logic [CHAN_COUNT-1:0] outputBleed,
   output logic [CHAN_COUNT-1:0] quiescentSaving,
   output logic [CHAN_COUNT*3-1:0] turnOnWaitCode,
   output logic faultIrq
);
   typedef enum logic [2:0] {
      KIND_NONE = 3'b001,
      KIND_LEVEL = 3'b010,
      KIND_CONTROL = 3'b100
   } lcr_kind_type;

   typedef struct packed {
      logic [CHAN_COUNT-1:0] goodMeta;
      logic [CHAN_COUNT-1:0] goodSync;
      logic [CHAN_COUNT-1:0] faultMeta;
      logic [CHAN_COUNT-1:0] faultSync;
      logic [7:0] readData;
      logic hit;
      logic irq;
   } lcr_bank_type;

   lcr_bank_type state;
   lcr_bank_type next_state;
   logic [CHAN_COUNT*6-1:0] levelAll;
   logic [CHAN_COUNT*7-1:0] controlAll;
   lcr_kind_type accessKind;
   logic [1:0] accessChan;
   logic [7:0] controlByte;
   logic [CHAN_COUNT-1:0] faultGated;

   // address decode into register kind and channel
   function automatic lcr_kind_type decode_kind(input logic [7:0] addr);
      case (addr)
         ADDR_A_LEVEL, ADDR_B_LEVEL, ADDR_C_LEVEL, ADDR_D_LEVEL: decode_kind = KIND_LEVEL;
         ADDR_A_CONTROL, ADDR_B_CONTROL, ADDR_C_CONTROL, ADDR_D_CONTROL: begin
            decode_kind = KIND_CONTROL;
         end
         default: decode_kind = KIND_NONE;
      endcase
   endfunction

   function automatic logic [1:0] decode_chan(input logic [7:0] addr);
      case (addr)
         ADDR_B_LEVEL, ADDR_B_CONTROL: decode_chan = 2'h1;
         ADDR_C_LEVEL, ADDR_C_CONTROL: decode_chan = 2'h2;
         ADDR_D_LEVEL, ADDR_D_CONTROL: decode_chan = 2'h3;
         default: decode_chan = 2'h0;
      endcase
   endfunction

   assign accessKind = decode_kind(regAddr);
   assign accessChan = decode_chan(regAddr);

   // storage of writable fields
   lcr_chan_mem u_mem (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .writeLevel(regWrite && accessKind == KIND_LEVEL), // RL8
      .writeControl(regWrite && accessKind == KIND_CONTROL), // RL8
      .chanSel(accessChan),
      .writeData(regWriteData),
      .levelAll(levelAll),
      .controlAll(controlAll)
   );

   // read byte for the addressed control register, good bit live
   always_comb begin
      controlByte = {controlAll[accessChan*7 +: 7], state.goodSync[accessChan]}; // RL7
   end

   // synchronise pins, register read data and interrupt
   always_comb begin
      next_state = state;
      next_state.goodMeta = powerGoodPin;
      next_state.goodSync = state.goodMeta;
      next_state.faultMeta = faultPin;
      next_state.faultSync = state.faultMeta;
      next_state.hit = regRead && accessKind != KIND_NONE;
      if (regRead) begin
         case (accessKind)
            KIND_LEVEL: next_state.readData = {2'b00, levelAll[accessChan*6 +: 6]}; // RL1
            KIND_CONTROL: next_state.readData = controlByte;
            default: next_state.readData = UNMAPPED_READ; // RL8
         endcase
      end
      next_state.irq = |faultGated;
   end

   // state registers
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // fan stored fields out to the channels
   always_comb begin
      for (int i = 0; i < CHAN_COUNT; i++) begin
         chanEnable[i] = controlAll[i*7 + BIT_ENABLE - 1]; // RL2
         outputBleed[i] = controlAll[i*7 + BIT_BLEED - 1] && !chanEnable[i]; // RL3
         quiescentSaving[i] = controlAll[i*7 + BIT_QUIET - 1]; // RL4
         turnOnWaitCode[i*3 +: 3] = controlAll[i*7 + WAIT_LSB - 1 +: 3]; // RL5
         faultGated[i] = controlAll[i*7 + BIT_FAULT_ALLOW - 1] && state.faultSync[i]; // RL6
      end
   end

   assign outputLevelCode = levelAll;
   assign regReadData = state.readData;
   assign regHit = state.hit;
   assign faultIrq = state.irq;

   // fault with allow set raises irq one cycle later
   sequence s_fault_allowed(int ch);
      state.faultSync[ch] && controlAll[ch*7 + BIT_FAULT_ALLOW - 1];
   endsequence

   AST_IRQ_ON_FAULT: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL6
      s_fault_allowed(0) |=> faultIrq)
      else $error("fault allowed but no interrupt");
   AST_IRQ_MASKED: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL6
      (faultGated == '0) |=> !faultIrq)
      else $error("interrupt without allowed fault");
   AST_LEVEL_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL1
      (regWrite && regAddr == ADDR_A_LEVEL) |=>
      outputLevelCode[5:0] == $past(regWriteData[5:0]))
      else $error("level write not stored");
   AST_LEVEL_RESERVED: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL1
      $past(regRead) && $past(accessKind) == KIND_LEVEL |-> regReadData[7:6] == 2'b00)
      else $error("reserved level bits nonzero");
   AST_ENABLE_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL2
      (regWrite && regAddr == ADDR_B_CONTROL) |=>
      chanEnable[1] == $past(regWriteData[BIT_ENABLE]))
      else $error("enable write not applied");
   AST_BLEED_ONLY_OFF: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL3
      chanEnable[0] |-> !outputBleed[0])
      else $error("bleed active while enabled");
   AST_QUIET_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL4
      (regWrite && regAddr == ADDR_C_CONTROL) |=>
      quiescentSaving[2] == $past(regWriteData[BIT_QUIET]))
      else $error("quiet write not applied");
   AST_WAIT_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL5
      (regWrite && regAddr == ADDR_D_CONTROL) |=>
      turnOnWaitCode[11:9] == $past(regWriteData[WAIT_MSB:WAIT_LSB]))
      else $error("wait code write not applied");
   AST_GOOD_LIVE: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL7
      (regRead && regAddr == ADDR_A_CONTROL) |=> regReadData[BIT_GOOD] == $past(state.goodSync[0]))
      else $error("good bit not live");
   AST_UNMAPPED_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL8
      (regWrite && accessKind == KIND_NONE) |=> $stable(levelAll) && $stable(controlAll))
      else $error("unmapped write changed state");

   // register port steps shared by the properties below
   sequence s_write_to(logic [7:0] addr);
      regWrite && regAddr == addr;
   endsequence

   sequence s_read_of(logic [7:0] addr);
      regRead && regAddr == addr;
   endsequence

   // pin levels held long enough to pass both synchroniser stages
   sequence s_good_held(int ch);
      powerGoodPin[ch] [*3];
   endsequence

   sequence s_good_low(int ch);
      (!powerGoodPin[ch]) [*3];
   endsequence

   sequence s_fault_pin_held(int ch);
      (faultPin[ch] && controlAll[ch*7 + BIT_FAULT_ALLOW - 1]) [*3];
   endsequence

   sequence s_no_fault_pins;
      (faultPin == '0) [*3];
   endsequence

   // level writes land on every channel, reserved bits dropped
   AST_LEVEL_WRITE_B: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL1
      s_write_to(ADDR_B_LEVEL) |=>
      outputLevelCode[11:6] == $past(regWriteData[LEVEL_MSB:0]))
      else $error("level write to channel b not stored");
   AST_LEVEL_WRITE_C: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL1
      s_write_to(ADDR_C_LEVEL) |=>
      outputLevelCode[17:12] == $past(regWriteData[LEVEL_MSB:0]))
      else $error("level write to channel c not stored");
   AST_LEVEL_WRITE_D: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL1
      s_write_to(ADDR_D_LEVEL) |=>
      outputLevelCode[23:18] == $past(regWriteData[LEVEL_MSB:0]))
      else $error("level write to channel d not stored");
   AST_LEVEL_READBACK: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL1
      s_read_of(ADDR_C_LEVEL) |=>
      regReadData == {2'b00, $past(outputLevelCode[17:12])})
      else $error("level read differs from stored code");

   // enable bit drives the channel and reads back
   AST_ENABLE_WRITE_C: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL2
      s_write_to(ADDR_C_CONTROL) |=>
      chanEnable[2] == $past(regWriteData[BIT_ENABLE]))
      else $error("enable write to channel c not applied");
   AST_ENABLE_WRITE_D: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL2
      s_write_to(ADDR_D_CONTROL) |=>
      chanEnable[3] == $past(regWriteData[BIT_ENABLE]))
      else $error("enable write to channel d not applied");
   AST_ENABLE_READBACK: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL2
      s_read_of(ADDR_B_CONTROL) |=>
      regReadData[BIT_ENABLE] == $past(chanEnable[1]))
      else $error("enable bit reads back wrong");

   // bleed follows its bit only while the channel is off
   AST_BLEED_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL3
      (s_write_to(ADDR_A_CONTROL) ##0 !regWriteData[BIT_ENABLE]) |=>
      outputBleed[0] == $past(regWriteData[BIT_BLEED]))
      else $error("bleed select not applied in shutdown");
   AST_BLEED_READBACK: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL3
      (s_read_of(ADDR_D_CONTROL) ##0 !chanEnable[3]) |=>
      regReadData[BIT_BLEED] == $past(outputBleed[3]))
      else $error("bleed bit reads back wrong");

   // low quiescent select on further channels
   AST_QUIET_WRITE_A: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL4
      s_write_to(ADDR_A_CONTROL) |=>
      quiescentSaving[0] == $past(regWriteData[BIT_QUIET]))
      else $error("quiet write to channel a not applied");
   AST_QUIET_READBACK: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL4
      s_read_of(ADDR_A_CONTROL) |=>
      regReadData[BIT_QUIET] == $past(quiescentSaving[0]))
      else $error("quiet bit reads back wrong");

   // wait code stored whole and read back whole
   AST_WAIT_WRITE_B: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL5
      s_write_to(ADDR_B_CONTROL) |=>
      turnOnWaitCode[5:3] == $past(regWriteData[WAIT_MSB:WAIT_LSB]))
      else $error("wait code write to channel b not applied");
   AST_WAIT_READBACK: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL5
      s_read_of(ADDR_C_CONTROL) |=>
      regReadData[WAIT_MSB:WAIT_LSB] == $past(turnOnWaitCode[8:6]))
      else $error("wait code reads back wrong");
   AST_FIELDS_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL5
      !regWrite |=> $stable(outputLevelCode) && $stable(turnOnWaitCode)
         && $stable(chanEnable) && $stable(quiescentSaving))
      else $error("channel fields moved without a write");

   // fault pins reach the interrupt only through the allow bit
   AST_ALLOW_CLEARED: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL6
      (s_write_to(ADDR_D_CONTROL) ##0 !regWriteData[BIT_FAULT_ALLOW]) |=>
      !faultGated[3])
      else $error("cleared allow still passes fault");
   AST_PIN_TO_IRQ: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL6
      s_fault_pin_held(1) |=> faultIrq)
      else $error("held fault did not raise interrupt");
   AST_IRQ_CLEARS: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL6
      s_no_fault_pins |=> !faultIrq)
      else $error("interrupt without any fault pin");

   // good bit follows the synchronised pin, never a written value
   AST_GOOD_HIGH: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL7
      (s_good_held(2) ##0 s_read_of(ADDR_C_CONTROL)) |=>
      regReadData[BIT_GOOD])
      else $error("good pin high but bit reads zero");
   AST_GOOD_LOW: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL7
      (s_good_low(2) ##0 s_read_of(ADDR_C_CONTROL)) |=>
      !regReadData[BIT_GOOD])
      else $error("good pin low but bit reads one");
   AST_GOOD_NOT_STORED: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL8
      s_write_to(ADDR_A_CONTROL) |=>
      controlAll[6:0] == $past(regWriteData[7:1]))
      else $error("control write stored wrong bits");

   // unmapped reads answer zero, hit marks only mapped reads
   AST_UNMAPPED_READ: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL8
      (regRead && accessKind == KIND_NONE) |=>
      !regHit && regReadData == UNMAPPED_READ)
      else $error("unmapped read answered");
   AST_HIT_ONE_CYCLE: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL8
      !regRead |=> !regHit)
      else $error("hit without a read");
endmodule
`default_nettype wire

/* File: verification/lcr_host.sv */
// host model: single byte reads and writes on the register port
// assumes the bank takes a strobe at the rising edge of clk_sys
`timescale 1ns/1ps
`default_nettype none
module lcr_host
   import lcr_pkg::*;
(
   // clock
   input wire logic clk_sys,
   // register port
   output logic regWrite,
   output logic regRead,
   output logic [7:0] regAddr,
   output logic [7:0] regWriteData
);
   // idle port at time zero
   initial begin
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 8'h00;
      regWriteData = 8'h00;
   end
   // strobe held over one sampling edge, then one idle cycle
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
      regWrite = wr;
      regRead = !wr;
      regAddr = a;
      regWriteData = d;
      @(posedge clk_sys);
      #1;
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = ~a; // released lines do not keep the old value
      regWriteData = ~d;
      @(posedge clk_sys);
      #1;
   endtask
endmodule
`default_nettype wire

/* File: verification/tb_lcr_bank.sv */
// self-checking bench for the regulator register bank
// assumes lcr_host drives the register port, bench drives the pins
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
   $display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb_lcr_bank
   import lcr_pkg::*;
;
   logic clk_sys, rst_b, regWrite, regRead, regHit, faultIrq, rdSeen = 1'b0;
   logic [7:0] regAddr, regWriteData, regReadData, lvl, ctl;
   logic [3:0] powerGoodPin, faultPin, chanEnable, outputBleed, quiescentSaving;
   logic [23:0] outputLevelCode;
   logic [11:0] turnOnWaitCode;
   logic [15:0] seed = 16'h382a;
   logic [8:0] expQ[$];
   logic [8:0] got;
   logic [7:0] lvAddr[4] = '{ADDR_A_LEVEL, ADDR_B_LEVEL, ADDR_C_LEVEL, ADDR_D_LEVEL};
   int miscompares = 0, comparisons = 0, cycles = 0, i;
   lcr_host host (.clk_sys, .regWrite, .regRead, .regAddr, .regWriteData);
   lcr_bank dut (.clk_sys, .rst_b, .regWrite, .regRead, .regAddr, .regWriteData,
      .regReadData, .regHit, .powerGoodPin, .faultPin, .outputLevelCode, .chanEnable,
      .outputBleed, .quiescentSaving, .turnOnWaitCode, .faultIrq);
   // random source
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // verdict and end of run
   task automatic print_verdict();
      if (miscompares == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // clock
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // read watcher: oldest note against the answer after each read
   always @(posedge clk_sys) begin
      #2;
      if (rdSeen) begin
         got = expQ.pop_front();
         `CHK("read", got, {regHit, regReadData})
      end
      rdSeen = regRead;
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         print_verdict();
      end
   end
   // main sequence: each channel twice with random codes
   initial begin
      rst_b = 1'b0;
      powerGoodPin = 4'h0;
      faultPin = 4'h0;
      repeat (16) @(posedge clk_sys);
      #1;
      rst_b = 1'b1;
      for (int k = 0; k < 8; k++) begin
         i = k % 4;
         seed = nxt(seed);
         lvl = seed[7:0];
         ctl = seed[15:8];
         powerGoodPin = seed[12:9];
         host.access(1'b1, lvAddr[i], lvl | 8'hc0);
         `CHK("level", lvl[5:0], outputLevelCode[i*6 +: 6])
         host.access(1'b1, lvAddr[i] + 8'h01, ctl | 8'h01);
         `CHK("enable", ctl[7], chanEnable[i])
         `CHK("bleed", ctl[6] & ~ctl[7], outputBleed[i])
         `CHK("quiet", ctl[5], quiescentSaving[i])
         `CHK("wait", ctl[4:2], turnOnWaitCode[i*3 +: 3])
         expQ.push_back({1'b1, 2'b00, lvl[5:0]});
         host.access(1'b0, lvAddr[i], 8'h00);
         expQ.push_back({1'b1, ctl[7:1], powerGoodPin[i]});
         host.access(1'b0, lvAddr[i] + 8'h01, 8'h00);
         faultPin[i] = 1'b1;
         repeat (4) @(posedge clk_sys) #1;
         `CHK("irq", ctl[1], faultIrq)
         faultPin[i] = 1'b0;
         repeat (4) @(posedge clk_sys) #1;
      end
      // unmapped read answers zero without a hit
      expQ.push_back(9'h000);
      host.access(1'b0, 8'h52, 8'h00);
      repeat (2) @(posedge clk_sys);
      print_verdict();
   end
endmodule
`default_nettype wire
